// [core/_unused.sv]
// Holds no design unit; the lookup stage lives in the other core files

// [core/color_table.sv]
// One 256 x 8 colour translation table in flip-flops
`timescale 1ns/1ps
module color_table (
   input  wire logic       clk_in,
   input  wire logic       wr_en_in,
   input  wire logic [7:0] wr_index_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic [7:0] pix_index_in,
   input  wire logic [7:0] host_index_in,
   output logic      [7:0] pix_data_out,
   output logic      [7:0] host_data_out
);
   // No reset: contents are undefined until software loads them
   logic [pixel_lookup_pkg::DATA_W-1:0] entry_reg [pixel_lookup_pkg::TABLE_DEPTH];

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         entry_reg[wr_index_in] <= wr_data_in;
      end
   end

   // Separate read ports so host access never steals a pixel lookup
   assign pix_data_out  = entry_reg[pix_index_in];
   assign host_data_out = entry_reg[host_index_in];
endmodule : color_table

// [core/pixel_color_lookup.sv]
// Pixel colour lookup stage with host table programming over packets
`timescale 1ns/1ps
module pixel_color_lookup (
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic        low_power_in,
   input  wire logic [7:0]  table_start_index_in,
   input  wire logic        pkt_start_in,
   input  wire logic [7:0]  pkt_addr_in,
   input  wire logic        pkt_write_in,
   input  wire logic        pkt_counted_in,
   input  wire logic [7:0]  pkt_count_in,
   input  wire logic        pkt_end_in,
   input  wire logic        wr_byte_valid_in,
   input  wire logic [7:0]  wr_byte_in,
   input  wire logic        rd_byte_req_in,
   output logic             rd_byte_valid_out,
   output logic      [7:0]  rd_byte_out,
   output logic      [7:0]  control_out,
   input  wire logic [1:0]  bus_width_select_in,
   input  wire logic [7:0]  red_in,
   input  wire logic [7:0]  green_in,
   input  wire logic [7:0]  blue_in,
   input  wire logic        horizontal_sync_in,
   input  wire logic        vertical_sync_in,
   input  wire logic        pixel_valid_in,
   output logic      [26:0] pixel_out
);

   // Selector of the register an address names
   function automatic logic [1:0] reg_select(input logic [7:0] addr);
      logic [1:0] sel;
      sel = pixel_lookup_pkg::SEL_CONTROL;
      case (addr)
         pixel_lookup_pkg::ADDR_RED:   sel = pixel_lookup_pkg::SEL_RED;
         pixel_lookup_pkg::ADDR_GREEN: sel = pixel_lookup_pkg::SEL_GREEN;
         pixel_lookup_pkg::ADDR_BLUE:  sel = pixel_lookup_pkg::SEL_BLUE;
         default:                      sel = pixel_lookup_pkg::SEL_CONTROL;
      endcase
      return sel;
   endfunction : reg_select

   function automatic logic reg_mapped(input logic [7:0] addr);
      return (addr == pixel_lookup_pkg::ADDR_CONTROL) ||
             (addr == pixel_lookup_pkg::ADDR_RED) ||
             (addr == pixel_lookup_pkg::ADDR_GREEN) ||
             (addr == pixel_lookup_pkg::ADDR_BLUE);
   endfunction : reg_mapped

   pixel_lookup_pkg::burst_state_t state_reg;
   logic [1:0]  sel_reg;
   logic [7:0]  index_reg;
   logic [8:0]  remain_reg;
   logic        counted_reg;
   logic [7:0]  ctrl_reg;
   logic        rd_valid_reg;
   logic [7:0]  rd_data_reg;
   logic [7:0]  comp_in   [pixel_lookup_pkg::COLORS];
   logic [7:0]  s1_comp_reg [pixel_lookup_pkg::COLORS];
   logic [2:0]  s1_en_reg;
   logic [2:0]  s1_sync_reg;
   logic [7:0]  pix_data  [pixel_lookup_pkg::COLORS];
   logic [7:0]  host_data [pixel_lookup_pkg::COLORS];
   logic [7:0]  color_out [pixel_lookup_pkg::COLORS];
   logic [26:0] pixel_reg;
   logic        room;
   logic        wr_fire;
   logic        rd_fire;
   logic        last_byte;
   logic        narrow;
   logic [7:0]  host_byte;

   // A counted burst stops taking bytes once its count is used up
   assign room      = !counted_reg || (remain_reg != pixel_lookup_pkg::BURST_ZERO);
   assign wr_fire   = (state_reg == pixel_lookup_pkg::ST_WRITE) && wr_byte_valid_in && room;
   assign rd_fire   = (state_reg == pixel_lookup_pkg::ST_READ) && rd_byte_req_in && room;
   assign last_byte = counted_reg && (remain_reg == pixel_lookup_pkg::BURST_STEP);
   assign narrow    = (bus_width_select_in == pixel_lookup_pkg::BWS_LOW);

   assign comp_in[0] = red_in;
   assign comp_in[1] = green_in;
   assign comp_in[2] = blue_in;

   // Burst sequencing
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= pixel_lookup_pkg::ST_IDLE;
      end else if (pkt_start_in) begin
         if (!reg_mapped(pkt_addr_in)) begin
            state_reg <= pixel_lookup_pkg::ST_IDLE;
         end else if (pkt_write_in) begin
            state_reg <= pixel_lookup_pkg::ST_WRITE;
         end else begin
            state_reg <= pixel_lookup_pkg::ST_READ;
         end
      end else begin
         case (state_reg)
            pixel_lookup_pkg::ST_WRITE: begin
               if (pkt_end_in || (wr_fire && last_byte)) begin
                  state_reg <= pixel_lookup_pkg::ST_IDLE;
               end
            end
            pixel_lookup_pkg::ST_READ: begin
               if (pkt_end_in || (rd_fire && last_byte)) begin
                  state_reg <= pixel_lookup_pkg::ST_IDLE;
               end
            end
            default: state_reg <= pixel_lookup_pkg::ST_IDLE;
         endcase
      end
   end

   // Target, index and remaining count of the current burst
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sel_reg     <= pixel_lookup_pkg::SEL_CONTROL;
         index_reg   <= pixel_lookup_pkg::COUNT_ZERO;
         remain_reg  <= pixel_lookup_pkg::BURST_ZERO;
         counted_reg <= 1'b0;
      end else if (pkt_start_in) begin
         sel_reg     <= reg_select(pkt_addr_in);
         index_reg   <= table_start_index_in;
         counted_reg <= pkt_counted_in;
         if (pkt_count_in == pixel_lookup_pkg::COUNT_ZERO) begin
            remain_reg <= pixel_lookup_pkg::FULL_BURST;
         end else begin
            remain_reg <= {1'b0, pkt_count_in};
         end
      end else if (wr_fire || rd_fire) begin
         index_reg  <= index_reg + pixel_lookup_pkg::INDEX_STEP;
         remain_reg <= remain_reg - pixel_lookup_pkg::BURST_STEP;
      end
   end

   // Control register; low power returns it to the reset value
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_reg <= pixel_lookup_pkg::CTRL_RESET;
      end else if (low_power_in) begin
         ctrl_reg <= pixel_lookup_pkg::CTRL_RESET;
      end else if (wr_fire && (sel_reg == pixel_lookup_pkg::SEL_CONTROL)) begin
         ctrl_reg <= wr_byte_in & pixel_lookup_pkg::CTRL_USED_MASK;
      end
   end

   assign host_byte = (sel_reg == pixel_lookup_pkg::SEL_CONTROL) ? ctrl_reg :
                      (sel_reg == pixel_lookup_pkg::SEL_RED)     ? host_data[0] :
                      (sel_reg == pixel_lookup_pkg::SEL_GREEN)   ? host_data[1] :
                                                                   host_data[2];

   // Every read request gets an answer; requests outside a burst read zero
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg  <= pixel_lookup_pkg::READ_IDLE;
      end else begin
         rd_valid_reg <= rd_byte_req_in;
         if (rd_fire) begin
            rd_data_reg <= host_byte;
         end else begin
            rd_data_reg <= pixel_lookup_pkg::READ_IDLE;
         end
      end
   end

   // First pipeline stage: capture the split pixel and the enables in force
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_en_reg   <= 3'h0;
         s1_sync_reg <= 3'h0;
      end else begin
         // Program mode wins so host table access cannot corrupt the picture
         s1_en_reg   <= ctrl_reg[pixel_lookup_pkg::CTRL_PROG_BIT] ? 3'h0 :
                        {ctrl_reg[pixel_lookup_pkg::CTRL_BLUE_BIT],
                         ctrl_reg[pixel_lookup_pkg::CTRL_GREEN_BIT],
                         ctrl_reg[pixel_lookup_pkg::CTRL_RED_BIT]};
         s1_sync_reg <= {pixel_valid_in, vertical_sync_in, horizontal_sync_in};
      end
   end

   generate
      for (genvar c = 0; c < pixel_lookup_pkg::COLORS; c++) begin : g_color
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               s1_comp_reg[c] <= pixel_lookup_pkg::COUNT_ZERO;
            end else if (narrow) begin
               s1_comp_reg[c] <= comp_in[c] & pixel_lookup_pkg::NARROW_MASK;
            end else begin
               s1_comp_reg[c] <= comp_in[c];
            end
         end

         color_table u_table (
            .clk_in        (clk_in),
            .wr_en_in      (wr_fire && (sel_reg == 2'(c))),
            .wr_index_in   (index_reg),
            .wr_data_in    (wr_byte_in),
            .pix_index_in  (s1_comp_reg[c]),
            .host_index_in (index_reg),
            .pix_data_out  (pix_data[c]),
            .host_data_out (host_data[c])
         );

         // Disabled colours pass the captured component, with the top two bits cleared in narrow mode
         assign color_out[c] = s1_en_reg[c] ? pix_data[c] : s1_comp_reg[c];
      end
   endgenerate

   // Second stage: pack the parallel output word
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pixel_reg <= 27'h0000000;
      end else begin
         pixel_reg[pixel_lookup_pkg::RED_LO+:pixel_lookup_pkg::LOW_W]   <=
            color_out[0][pixel_lookup_pkg::LOW_W-1:0];
         pixel_reg[pixel_lookup_pkg::GREEN_LO+:pixel_lookup_pkg::LOW_W] <=
            color_out[1][pixel_lookup_pkg::LOW_W-1:0];
         pixel_reg[pixel_lookup_pkg::BLUE_LO+:pixel_lookup_pkg::LOW_W]  <=
            color_out[2][pixel_lookup_pkg::LOW_W-1:0];
         pixel_reg[pixel_lookup_pkg::HS_BIT]    <= s1_sync_reg[0];
         pixel_reg[pixel_lookup_pkg::VS_BIT]    <= s1_sync_reg[1];
         pixel_reg[pixel_lookup_pkg::VALID_BIT] <= s1_sync_reg[2];
         pixel_reg[pixel_lookup_pkg::RED_HI+:pixel_lookup_pkg::HIGH_W]   <=
            color_out[0][pixel_lookup_pkg::DATA_W-1:pixel_lookup_pkg::LOW_W];
         pixel_reg[pixel_lookup_pkg::GREEN_HI+:pixel_lookup_pkg::HIGH_W] <=
            color_out[1][pixel_lookup_pkg::DATA_W-1:pixel_lookup_pkg::LOW_W];
         pixel_reg[pixel_lookup_pkg::BLUE_HI+:pixel_lookup_pkg::HIGH_W]  <=
            color_out[2][pixel_lookup_pkg::DATA_W-1:pixel_lookup_pkg::LOW_W];
      end
   end

   assign rd_byte_valid_out = rd_valid_reg;
   assign rd_byte_out       = rd_data_reg;
   assign control_out       = ctrl_reg;
   assign pixel_out         = pixel_reg;

   // Checks
   property p_full_count;
      @(posedge clk_in) disable iff (!resetn_in)
      pkt_start_in && (pkt_count_in == 8'h00) |=> remain_reg == 9'h100;
   endproperty
   a_full_count: assert property (p_full_count)
      else $error("zero count did not load a full burst");

   property p_restart_index;
      @(posedge clk_in) disable iff (!resetn_in)
      pkt_start_in |=> index_reg == $past(table_start_index_in);
   endproperty
   a_restart_index: assert property (p_restart_index)
      else $error("packet did not restart at start index");

   property p_advance;
      @(posedge clk_in) disable iff (!resetn_in)
      (wr_fire || rd_fire) && !pkt_start_in |=> index_reg == $past(index_reg) + 8'h01;
   endproperty
   a_advance: assert property (p_advance)
      else $error("index did not advance after a byte");

   property p_read_answer;
      @(posedge clk_in) disable iff (!resetn_in)
      rd_byte_req_in |=> rd_byte_valid_out;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read request not answered in one cycle");

   // No request, no answer: the data lines rest at the idle value
   property p_read_idle;
      @(posedge clk_in) disable iff (!resetn_in)
      !rd_byte_req_in |=> !rd_byte_valid_out && (rd_byte_out == pixel_lookup_pkg::READ_IDLE);
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read answer without a request");

   property p_low_power_off;
      @(posedge clk_in) disable iff (!resetn_in)
      low_power_in |=> control_out == 8'h00;
   endproperty
   a_low_power_off: assert property (p_low_power_off)
      else $error("translation still configured after low power");

   property p_sync_latency;
      @(posedge clk_in) disable iff (!resetn_in)
      ##2 (pixel_out[pixel_lookup_pkg::HS_BIT] == $past(horizontal_sync_in, 2)) &&
          (pixel_out[pixel_lookup_pkg::VS_BIT] == $past(vertical_sync_in, 2)) &&
          (pixel_out[pixel_lookup_pkg::VALID_BIT] == $past(pixel_valid_in, 2));
   endproperty
   a_sync_latency: assert property (p_sync_latency)
      else $error("sync or valid misaligned with pipeline");

   property p_passthrough;
      @(posedge clk_in) disable iff (!resetn_in)
      !s1_en_reg[0] |=> pixel_out[5:0] == $past(s1_comp_reg[0][5:0]);
   endproperty
   a_passthrough: assert property (p_passthrough)
      else $error("disabled red component was altered");

   property p_prog_suspends;
      @(posedge clk_in) disable iff (!resetn_in)
      ctrl_reg[pixel_lookup_pkg::CTRL_PROG_BIT] |=> s1_en_reg == 3'h0;
   endproperty
   a_prog_suspends: assert property (p_prog_suspends)
      else $error("translation active during program mode");

   property p_narrow_index;
      @(posedge clk_in) disable iff (!resetn_in)
      bus_width_select_in == 2'h0 |=> s1_comp_reg[1][7:6] == 2'b00;
   endproperty
   a_narrow_index: assert property (p_narrow_index)
      else $error("narrow mode index above 0x3F");

   property p_count_stop;
      @(posedge clk_in) disable iff (!resetn_in)
      wr_fire && last_byte && !pkt_start_in |=> state_reg == pixel_lookup_pkg::ST_IDLE;
   endproperty
   a_count_stop: assert property (p_count_stop)
      else $error("counted burst ran past its count");

   c_full_write: cover property (@(posedge clk_in) disable iff (!resetn_in)
      wr_fire && last_byte && (remain_reg == 9'h001));
   c_table_read: cover property (@(posedge clk_in) disable iff (!resetn_in)
      rd_fire && (sel_reg == 2'h2));
   c_translate: cover property (@(posedge clk_in) disable iff (!resetn_in)
      s1_en_reg == 3'h7);
endmodule : pixel_color_lookup

// [inc/pixel_lookup_pkg.sv]
// Constants and types shared by the pixel colour lookup stage
package pixel_lookup_pkg;
   localparam int COLORS       = 3;
   localparam int DATA_W       = 8;
   localparam int INDEX_W      = 8;
   localparam int TABLE_DEPTH  = 256;
   localparam int LOW_W        = 6;
   localparam int HIGH_W       = 2;
   localparam int OUT_W        = 27;
   localparam int PIPE_DEPTH   = 2;

   // Register addresses on the control channel
   localparam logic [7:0] ADDR_CONTROL = 8'h7C;
   localparam logic [7:0] ADDR_RED     = 8'h7D;
   localparam logic [7:0] ADDR_GREEN   = 8'h7E;
   localparam logic [7:0] ADDR_BLUE    = 8'h7F;

   // Control register layout
   localparam int CTRL_RED_BIT   = 0;
   localparam int CTRL_GREEN_BIT = 1;
   localparam int CTRL_BLUE_BIT  = 2;
   localparam int CTRL_PROG_BIT  = 3;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] CTRL_USED_MASK = 8'h0F;

   // Burst length handling
   localparam logic [8:0] FULL_BURST  = 9'h100;
   localparam logic [8:0] BURST_ZERO  = 9'h000;
   localparam logic [8:0] BURST_STEP  = 9'h001;
   localparam logic [7:0] INDEX_STEP  = 8'h01;
   localparam logic [7:0] COUNT_ZERO  = 8'h00;
   localparam logic [7:0] READ_IDLE   = 8'h00;

   // 18-bit colour keeps only the low six bits of each component
   localparam logic [7:0] NARROW_MASK = 8'h3F;

   // Selectors of the addressed register
   localparam logic [1:0] SEL_RED     = 2'h0;
   localparam logic [1:0] SEL_GREEN   = 2'h1;
   localparam logic [1:0] SEL_BLUE    = 2'h2;
   localparam logic [1:0] SEL_CONTROL = 2'h3;

   // Parallel output field positions
   localparam int RED_LO   = 0;
   localparam int GREEN_LO = 6;
   localparam int BLUE_LO  = 12;
   localparam int HS_BIT   = 18;
   localparam int VS_BIT   = 19;
   localparam int VALID_BIT = 20;
   localparam int RED_HI   = 21;
   localparam int GREEN_HI = 23;
   localparam int BLUE_HI  = 25;

   typedef enum logic [1:0] {
      BWS_LOW  = 2'h0,
      BWS_HIGH = 2'h1,
      BWS_OPEN = 2'h2
   } bus_width_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WRITE = 2'b01,
      ST_READ  = 2'b10
   } burst_state_t;
endpackage : pixel_lookup_pkg

// [verification/host_ctrl_model.sv]
// Host controller model issuing table and control packets
`timescale 1ns/1ps
module host_ctrl_model (
   input  wire logic       clk_in,
   input  wire logic       rd_byte_valid_in,
   input  wire logic [7:0] rd_byte_in,
   output logic      [7:0] table_start_index_out,
   output logic            pkt_start_out,
   output logic      [7:0] pkt_addr_out,
   output logic            pkt_write_out,
   output logic            pkt_counted_out,
   output logic      [7:0] pkt_count_out,
   output logic            pkt_end_out,
   output logic            wr_byte_valid_out,
   output logic      [7:0] wr_byte_out,
   output logic            rd_byte_req_out
);
   logic [7:0] got [256];

   initial begin
      {pkt_start_out, pkt_write_out, pkt_counted_out, pkt_end_out} = 4'h0;
      {wr_byte_valid_out, rd_byte_req_out} = 2'h0;
      {table_start_index_out, pkt_addr_out, pkt_count_out, wr_byte_out} = 32'h0;
   end

   task automatic open_pkt(input logic [7:0] a, idx, cnt, input logic wr, cntd);
      @(posedge clk_in);
      table_start_index_out <= idx;
      {pkt_addr_out, pkt_count_out} <= {a, cnt};
      {pkt_start_out, pkt_write_out, pkt_counted_out} <= {1'b1, wr, cntd};
   endtask : open_pkt

   // Stop condition ends every burst; counted ones are already done
   task automatic close_pkt();
      @(posedge clk_in);
      {pkt_start_out, wr_byte_valid_out, rd_byte_req_out} <= 3'h0;
      pkt_end_out <= 1'b1;
      wr_byte_out <= ~wr_byte_out;
      @(posedge clk_in);
      pkt_end_out <= 1'b0;
   endtask : close_pkt

   task automatic wr_pkt(input logic [7:0] a, idx, cnt, input logic cntd,
                         input logic [7:0] d [256], input int n);
      open_pkt(a, idx, cnt, 1'b1, cntd);
      for (int k = 0; k < n; k++) begin
         @(posedge clk_in);
         pkt_start_out <= 1'b0;
         wr_byte_valid_out <= 1'b1;
         wr_byte_out <= d[8'(idx + k)];
      end
      close_pkt();
   endtask : wr_pkt

   // Unflagged answer is stored as unknown so it can never match
   task automatic rd_pkt(input logic [7:0] a, idx, cnt, input logic cntd, input int n);
      open_pkt(a, idx, cnt, 1'b0, cntd);
      for (int k = 0; k < n + 2; k++) begin
         @(posedge clk_in);
         pkt_start_out <= 1'b0;
         rd_byte_req_out <= (k < n);
         if (k >= 2) got[8'(idx + k - 2)] = rd_byte_valid_in ? rd_byte_in : 8'hXX;
      end
      close_pkt();
   endtask : rd_pkt
endmodule : host_ctrl_model

// [verification/tb_top.sv]
// Self-checking bench for the pixel colour lookup stage
`timescale 1ns/1ps
module tb_top;
   logic        clk_in, resetn_in, low_power_in, hs, vs, de;
   logic [1:0]  bus_width_select;
   logic [7:0]  red, green, blue, start_idx, addr, count, wbyte, rbyte, control;
   logic        pstart, pwrite, pcounted, pend, wvalid, rreq, rvalid;
   logic [26:0] pixel_out;
   logic [7:0]  tr [3][256];
   logic [7:0]  cbuf [256];
   int          err_count;
   int          compares;

   pixel_color_lookup dut (
      .clk_in(clk_in), .resetn_in(resetn_in), .low_power_in(low_power_in),
      .table_start_index_in(start_idx), .pkt_start_in(pstart), .pkt_addr_in(addr),
      .pkt_write_in(pwrite), .pkt_counted_in(pcounted), .pkt_count_in(count),
      .pkt_end_in(pend), .wr_byte_valid_in(wvalid), .wr_byte_in(wbyte),
      .rd_byte_req_in(rreq), .rd_byte_valid_out(rvalid), .rd_byte_out(rbyte),
      .control_out(control), .bus_width_select_in(bus_width_select), .red_in(red),
      .green_in(green), .blue_in(blue), .horizontal_sync_in(hs),
      .vertical_sync_in(vs), .pixel_valid_in(de), .pixel_out(pixel_out)
   );

   host_ctrl_model host (
      .clk_in(clk_in), .rd_byte_valid_in(rvalid), .rd_byte_in(rbyte),
      .table_start_index_out(start_idx), .pkt_start_out(pstart),
      .pkt_addr_out(addr), .pkt_write_out(pwrite), .pkt_counted_out(pcounted),
      .pkt_count_out(count), .pkt_end_out(pend), .wr_byte_valid_out(wvalid),
      .wr_byte_out(wbyte), .rd_byte_req_out(rreq)
   );

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic chk(input logic [26:0] got, exp, input string m);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   function automatic logic [26:0] pk(input logic [7:0] r, g, b, input logic [2:0] s);
      return {b[7:6], g[7:6], r[7:6], s[0], s[1], s[2], b[5:0], g[5:0], r[5:0]};
   endfunction : pk

   // Input is changed the next cycle, so only a two-cycle delay matches
   task automatic px(input logic [7:0] r, g, b, input logic [2:0] s, input logic [26:0] e);
      @(posedge clk_in);
      {red, green, blue, hs, vs, de} <= {r, g, b, s};
      @(posedge clk_in);
      {red, green, blue, hs, vs, de} <= ~{r, g, b, s};
      @(posedge clk_in);
      #1 chk(pixel_out, e, "pixel");
   endtask : px

   task automatic ctl(input logic [7:0] v);
      cbuf[0] = v;
      host.wr_pkt(pixel_lookup_pkg::ADDR_CONTROL, 8'h00, 8'h01, 1'b1, cbuf, 1);
      chk(27'(control), 27'(v), "control");
   endtask : ctl

   task automatic t_reset();
      chk(27'(control), 27'h0, "reset control");
      bus_width_select <= pixel_lookup_pkg::BWS_HIGH;
      px(8'hC3, 8'h3C, 8'h96, 3'h5, pk(8'hC3, 8'h3C, 8'h96, 3'h5));
      $display("test reset done");
   endtask : t_reset

   task automatic t_program();
      ctl(8'h08);
      host.rd_pkt(pixel_lookup_pkg::ADDR_CONTROL, 8'h00, 8'h01, 1'b1, 1);
      chk(27'(host.got[0]), 27'h08, "control read");
      px(8'h12, 8'hE4, 8'h7F, 3'h2, pk(8'h12, 8'hE4, 8'h7F, 3'h2));
      host.wr_pkt(pixel_lookup_pkg::ADDR_RED, 8'h00, 8'h00, 1'b1, tr[0], 256);
      host.wr_pkt(pixel_lookup_pkg::ADDR_GREEN, 8'h00, 8'h00, 1'b0, tr[1], 100);
      host.wr_pkt(pixel_lookup_pkg::ADDR_GREEN, 8'hC8, 8'h00, 1'b0, tr[1], 56);
      host.wr_pkt(pixel_lookup_pkg::ADDR_GREEN, 8'h64, 8'h00, 1'b0, tr[1], 100);
      host.wr_pkt(pixel_lookup_pkg::ADDR_BLUE, 8'h00, 8'h40, 1'b1, tr[2], 64);
      for (int c = 0; c < 3; c++) begin
         host.rd_pkt(8'h7D + 8'(c), 8'h00, (c == 2) ? 8'h40 : 8'h00, 1'b1, (c == 2) ? 64 : 256);
         for (int i = 0; i < ((c == 2) ? 64 : 256); i++)
            chk(27'(host.got[i]), 27'(tr[c][i]), "table read");
      end
      host.rd_pkt(8'h40, 8'h00, 8'h01, 1'b1, 1);
      chk(27'(host.got[0]), 27'h0, "unmapped read");
      $display("test program done");
   endtask : t_program

   task automatic t_translate();
      ctl(8'h07);
      px(8'hC3, 8'h3C, 8'h2B, 3'h3, pk(tr[0][8'hC3], tr[1][8'h3C], tr[2][8'h2B], 3'h3));
      bus_width_select <= pixel_lookup_pkg::BWS_OPEN;
      px(8'hFE, 8'h81, 8'h3F, 3'h4, pk(tr[0][8'hFE], tr[1][8'h81], tr[2][8'h3F], 3'h4));
      ctl(8'h01);
      px(8'h44, 8'hB7, 8'hD9, 3'h6, pk(tr[0][8'h44], 8'hB7, 8'hD9, 3'h6));
      $display("test translate done");
   endtask : t_translate

   task automatic t_narrow();
      bus_width_select <= pixel_lookup_pkg::BWS_LOW;
      ctl(8'h04);
      px(8'hC5, 8'hFF, 8'hEA, 3'h7, pk(8'h05, 8'h3F, tr[2][8'h2A], 3'h7));
      ctl(8'h00);
      px(8'hC5, 8'h9A, 8'hEA, 3'h1, pk(8'h05, 8'h1A, 8'h2A, 3'h1));
      $display("test narrow done");
   endtask : t_narrow

   task automatic t_low_power();
      bus_width_select <= pixel_lookup_pkg::BWS_HIGH;
      ctl(8'h07);
      low_power_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      low_power_in <= 1'b0;
      chk(27'(control), 27'h0, "low power control");
      px(8'hC3, 8'h3C, 8'h2B, 3'h0, pk(8'hC3, 8'h3C, 8'h2B, 3'h0));
      $display("test low power done");
   endtask : t_low_power

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   initial begin
      {resetn_in, low_power_in, bus_width_select, red, green, blue, hs, vs, de} = '0;
      err_count = 0;
      compares = 0;
      for (int i = 0; i < 256; i++) begin
         tr[0][i] = 8'(i) ^ 8'h5A;
         tr[1][i] = ~8'(i);
         tr[2][i] = {2'h0, 6'(i) ^ 6'h15};
      end
      repeat (8) @(posedge clk_in);
      resetn_in <= 1'b1;
      t_reset();
      t_program();
      t_translate();
      t_narrow();
      t_low_power();
      tally_and_finish();
   end
endmodule : tb_top
